/* rtl/sram_pkg.sv */
// Package with constants and types shared by the burst SRAM core.
package sram_pkg;
  localparam int ADDR_W_DEF      = 10;
  localparam int LANES_DEF       = 4;
  localparam int LANE_W          = 9;
  localparam int SLEEP_ENTRY_CYC = 2;
  localparam int SLEEP_EXIT_CYC  = 2;
  localparam int CLK_PERIOD_NS   = 10;
  localparam int SLEEP_RECOVERY_TIME_CYC = SLEEP_EXIT_CYC;
  localparam int SLEEP_RECOVERY_TIME_NS  = SLEEP_RECOVERY_TIME_CYC * CLK_PERIOD_NS;
  localparam logic [1:0] BURST_STEP = 2'h1;
  localparam logic [1:0] CNT_RESET  = 2'h0;
  typedef enum logic [1:0] {op_idle, op_read, op_write} op_t;
  typedef enum logic [1:0] {pw_awake, pw_entering, pw_asleep, pw_exiting} pwr_t;
endpackage : sram_pkg

/* rtl/sleep_sync.sv */
// Two-flop synchroniser for the asynchronous sleep request.
`timescale 1ns/1ps
module sleep_sync (
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_r;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      meta_r   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule : sleep_sync

/* rtl/sram_burst_bytewrite_sleep.sv */
// Pipelined synchronous burst SRAM core with byte-lane writes and sleep mode.
//
// Function
// - Advance high steps counter regardless of selects.
// - Write data captured two edges after address.
// - Hold input high freezes all pipeline state.
// - Powers up deselected with data pins undriven.
// - Drive pins only for read with enable low.
// - Write from read/write low plus lane selects.
// - Read ignores every byte-lane select input.
// - All lanes high writes nothing, slot kept.
// - Wide selects a..d enable bytes 0..3.
// - Lane d alone writes byte three only.
// - Narrow organisation has two lane selects.
// - Unselected lanes stay unaltered in word.
// - Asynchronous sleep request enters low-power state.
// - Two cycles to enter, two to exit.
// - Memory contents kept intact while asleep.
// - Pending accesses at sleep may be lost.
`timescale 1ns/1ps
module sram_burst_bytewrite_sleep #(
  parameter int ADDR_W = sram_pkg::ADDR_W_DEF,
  parameter int LANES  = sram_pkg::LANES_DEF
) (
  input  wire logic                           mclk,
  input  wire logic                           resetn,
  input  wire logic [ADDR_W-1:0]              addr,
  input  wire logic                           chip_sel_n,
  input  wire logic                           load_or_advance,
  input  wire logic                           read_write,
  input  wire logic [LANES-1:0]               byte_lane_select_n,
  input  wire logic                           cycle_hold_n,
  input  wire logic                           burst_order,
  input  wire logic                           out_enable_n,
  input  wire logic                           sleep_request,
  input  wire logic [LANES*sram_pkg::LANE_W-1:0] dq_in,
  output logic      [LANES*sram_pkg::LANE_W-1:0] dq_out,
  output logic      [LANES-1:0]               dq_oe,
  output logic                                asleep
);
  import sram_pkg::*;

  localparam int DW    = LANES * LANE_W;
  localparam int DEPTH = 1 << ADDR_W;

  // -------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] base;
    logic [1:0]        cnt;
    op_t               burst_op;
    op_t               op1;
    logic [ADDR_W-1:0] a1;
    logic [LANES-1:0]  be1;
    op_t               op2;
    logic [ADDR_W-1:0] a2;
    logic [LANES-1:0]  be2;
    logic [DW-1:0]     dout;
    logic [LANES-1:0]  oe;
    pwr_t              pwr;
    logic [1:0]        pcnt;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  logic   sleep_sync_w;
  logic   in_sleep;
  logic   stalled;
  logic [ADDR_W-1:0] cur_addr;
  logic [1:0]        next_cnt;

  logic [DW-1:0] mem [DEPTH];

  // Interleaved order is the start index xor the beat count.
  function automatic logic [1:0] burst_bits(input logic [1:0] start, input logic [1:0] beat,
                                            input logic interleave);
    burst_bits = interleave ? (start ^ beat) : 2'(start + beat);
  endfunction : burst_bits

  // -------------------------------------------------------------------
  // Sleep request crossing
  // -------------------------------------------------------------------
  sleep_sync u_sleep_sync (
    .mclk     (mclk),
    .resetn   (resetn),
    .async_in (sleep_request),
    .sync_out (sleep_sync_w)
  );

  assign in_sleep = (st_r.pwr != pw_awake);
  // A high hold input turns the edge into a wait state.
  assign stalled  = cycle_hold_n;
  assign next_cnt = 2'(st_r.cnt + BURST_STEP);
  assign cur_addr = {st_r.base[ADDR_W-1:2],
                     burst_bits(st_r.base[1:0], next_cnt, burst_order)};

  // -------------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // Power sequencing counts two cycles each way.
    unique case (st_r.pwr)
      pw_awake: begin
        if (sleep_sync_w) begin
          st_nxt.pwr  = pw_entering;
          st_nxt.pcnt = 2'(SLEEP_ENTRY_CYC - 1);
        end
      end
      pw_entering: begin
        st_nxt.op1 = op_idle;
        st_nxt.op2 = op_idle;
        st_nxt.oe  = '0;
        if (st_r.pcnt == 2'h1) begin
          st_nxt.pwr = pw_asleep;
        end else begin
          st_nxt.pcnt = 2'(st_r.pcnt - 2'h1);
        end
      end
      pw_asleep: begin
        if (!sleep_sync_w) begin
          st_nxt.pwr  = pw_exiting;
          st_nxt.pcnt = 2'(SLEEP_EXIT_CYC - 1);
        end
      end
      pw_exiting: begin
        if (st_r.pcnt == 2'h1) begin
          st_nxt.pwr = pw_awake;
        end else begin
          st_nxt.pcnt = 2'(st_r.pcnt - 2'h1);
        end
      end
    endcase

    if (!in_sleep && !sleep_sync_w && !stalled) begin
      // Stage 1 from the bus.
      if (load_or_advance) begin
        st_nxt.cnt = next_cnt;
        st_nxt.op1 = st_r.burst_op;
        st_nxt.a1  = cur_addr;
      end else if (!chip_sel_n) begin
        st_nxt.base     = addr;
        st_nxt.cnt      = CNT_RESET;
        st_nxt.op1      = read_write ? op_read : op_write;
        st_nxt.burst_op = st_nxt.op1;
        st_nxt.a1       = addr;
      end else begin
        st_nxt.op1      = op_idle;
        st_nxt.burst_op = op_idle;
      end
      // Lane selects only matter for writes; taken at the data beat.
      st_nxt.be1 = '0;
      st_nxt.op2 = st_r.op1;
      st_nxt.a2  = st_r.a1;
      st_nxt.be2 = st_r.be1;
      if (st_r.op1 == op_read) begin
        st_nxt.dout = mem[st_r.a1];
        st_nxt.oe   = out_enable_n ? '0 : '1;
      end else begin
        st_nxt.oe = '0;
      end
    end else if (!in_sleep && !stalled) begin
      st_nxt.oe = '0;
    end
  end

  // -------------------------------------------------------------------
  // Registers and array
  // -------------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_r          <= '0;
      st_r.burst_op <= op_idle;
      st_r.op1      <= op_idle;
      st_r.op2      <= op_idle;
      st_r.pwr      <= pw_awake;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Write beat: second edge after the address, per-lane enables.
  // One process owns the array, so every lane is written from the same block.
  always_ff @(posedge mclk) begin
    for (int g = 0; g < LANES; g++) begin
      if (!in_sleep && !sleep_sync_w && !cycle_hold_n && st_r.op2 == op_write
          && !byte_lane_select_n[g]) begin
        mem[st_r.a2][g*LANE_W +: LANE_W] <= dq_in[g*LANE_W +: LANE_W];
      end
    end
  end
  // Lane d is bit 3 and lanes a/b are bits 0/1 of the select bus.
  // All selects high disables every lane and keeps the slot.
  // A two-lane build sets LANES to 2.
  // The array is never cleared by sleep.

  always_comb begin
    dq_out = st_r.dout;
    dq_oe  = st_r.oe;
    asleep = (st_r.pwr == pw_asleep);
  end
endmodule : sram_burst_bytewrite_sleep

/* tb/sram_ctrl_bus.sv */
// Controller-side data bus model feeding the SRAM write data pins.
`timescale 1ns/1ps
module sram_ctrl_bus #(parameter int W = 36) (
  input  wire logic         mclk,
  input  wire logic         drive,
  input  wire logic [W-1:0] data,
  output logic      [W-1:0] dq_in
);
  logic [W-1:0] alt_r = '0;
  // A released bus toggles every cycle so that no stale word can be captured.
  always @(posedge mclk) alt_r <= ~alt_r;
  assign dq_in = drive ? data : alt_r;
endmodule : sram_ctrl_bus

/* tb/sram_core_chk_sva.sv */
// Port-level checker for the burst SRAM core.
`timescale 1ns/1ps
module sram_core_chk #(parameter int LANES = 4) (
  input wire logic mclk, resetn, chip_sel_n, load_or_advance, read_write,
  input wire logic cycle_hold_n, out_enable_n, sleep_request, asleep,
  input wire logic [LANES*sram_pkg::LANE_W-1:0] dq_out,
  input wire logic [LANES-1:0] dq_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  wire go = !chip_sel_n && !load_or_advance && !cycle_hold_n && !sleep_request && !asleep;
  AST_PWRUP: assert property ($rose(resetn) |-> dq_oe == '0)
    else $error("data lanes driven after reset");
  AST_ALL_LANES: assert property (dq_oe != '0 |-> dq_oe == '1)
    else $error("read drove only some lanes");
  AST_SLP_IN: assert property ($rose(sleep_request) && !asleep |->
    !asleep [*2] ##[1:5] asleep) else $error("sleep entry time wrong");
  AST_SLP_OUT: assert property ($fell(sleep_request) && asleep |-> ##[1:6] !asleep)
    else $error("sleep exit too slow");
  AST_SLP_STAY: assert property (asleep && sleep_request |=> asleep)
    else $error("left sleep while requested");
  AST_HOLD: assert property (cycle_hold_n && !sleep_request && !asleep |=>
    $stable(dq_out) && $stable(dq_oe)) else $error("outputs moved in wait state");
  AST_WR_QUIET: assert property (go && !read_write ##1 !cycle_hold_n |=> dq_oe == '0)
    else $error("lanes driven in write beat");
  AST_RD_DRIVE: assert property (go && read_write ##1
    (!cycle_hold_n && !out_enable_n) |=> dq_oe == '1) else $error("read not driven");
endmodule : sram_core_chk
bind sram_burst_bytewrite_sleep sram_core_chk #(.LANES(LANES)) chk (.mclk(mclk),
  .resetn(resetn), .chip_sel_n(chip_sel_n), .load_or_advance(load_or_advance),
  .read_write(read_write), .cycle_hold_n(cycle_hold_n), .out_enable_n(out_enable_n),
  .sleep_request(sleep_request), .asleep(asleep), .dq_out(dq_out), .dq_oe(dq_oe));

/* tb/test_sram_burst_bytewrite_sleep.sv */
// Self-checking testbench for the burst SRAM core.
`timescale 1ns/1ps
module test_sram_burst_bytewrite_sleep;
  logic mclk = 0, resetn = 0, chip_sel_n = 1, load_or_advance = 0, read_write = 1;
  logic cycle_hold_n = 0, burst_order = 0, out_enable_n = 0, sleep_request = 0, drive = 0;
  logic [9:0]  addr = '0;
  logic [3:0]  byte_lane_select_n = '1, dq_oe;
  logic [35:0] wdata = '0, dq_in, dq_out;
  logic        asleep;
  logic [35:0] mem [16];
  int          bad_count = 0, cmp_count = 0, cyc = 0;
  sram_burst_bytewrite_sleep #(.ADDR_W(10), .LANES(4)) dut (.mclk(mclk), .resetn(resetn),
    .addr(addr), .chip_sel_n(chip_sel_n), .load_or_advance(load_or_advance),
    .read_write(read_write), .byte_lane_select_n(byte_lane_select_n),
    .cycle_hold_n(cycle_hold_n), .burst_order(burst_order), .out_enable_n(out_enable_n),
    .sleep_request(sleep_request), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .asleep(asleep));
  sram_ctrl_bus #(.W(36)) ctrl (.mclk(mclk), .drive(drive), .data(wdata), .dq_in(dq_in));
  initial forever #5 mclk = ~mclk;
  task automatic finish_test;
    $display("compares=%0d mismatches=%0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Address cycle, one idle cycle, then the data beat two edges later.
  task automatic access(input logic [9:0] a, input logic rd, input logic [3:0] ln,
                        input logic [35:0] d);
    @(negedge mclk);
    addr = a; chip_sel_n = 0; read_write = rd;
    @(negedge mclk);
    chip_sel_n = 1;
    @(negedge mclk);
    byte_lane_select_n = ln; wdata = d; drive = !rd;
    @(negedge mclk);
    drive = 0; byte_lane_select_n = '1;
  endtask : access
  task automatic wr(input logic [9:0] a, input logic [3:0] ln, input logic [35:0] d);
    access(a, 1'b0, ln, d);
    for (int g = 0; g < 4; g++) if (!ln[g]) mem[a[3:0]][9*g+:9] = d[9*g+:9];
  endtask : wr
  // Read data stands in the cycle after the edge that follows the address edge.
  task automatic rd(input logic [9:0] a, input logic [3:0] oe_exp);
    @(negedge mclk);
    addr = a; chip_sel_n = 0; read_write = 1;
    @(negedge mclk);
    chip_sel_n = 1;
    @(negedge mclk);
    chk(dq_out, mem[a[3:0]]);
    chk(36'(dq_oe), 36'(oe_exp));
  endtask : rd
  task automatic burst(input logic [9:0] a, input logic io);
    @(negedge mclk);
    addr = a; chip_sel_n = 0; read_write = 1; burst_order = io;
    @(negedge mclk);
    chip_sel_n = 1; load_or_advance = 1;
    for (int k = 0; k < 4; k++) begin
      @(negedge mclk);
      if (k == 2) load_or_advance = 0;
      chk(dq_out, mem[{a[3:2], a[1:0] ^ 2'(k)}]);
    end
    burst_order = 0;
  endtask : burst
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      finish_test;
    end
  end
  initial begin
    repeat (16) @(negedge mclk);
    resetn = 1;
    chk(36'(dq_oe), 36'h0);
    wr(10'h4, 4'h0, 36'h123456789); rd(10'h4, 4'hf);
    for (int g = 0; g < 4; g++) begin
      wr(10'h4, ~(4'h1 << g), 36'h6a5b4c3d2 ^ 36'(g)); rd(10'h4, 4'hf);
    end
    wr(10'h4, 4'hf, 36'h0); rd(10'h4, 4'hf);
    out_enable_n = 1;
    rd(10'h4, 4'h0);
    out_enable_n = 0;
    for (int i = 8; i < 12; i++) wr(10'(i), 4'h0, 36'h0f0f0f000 + 36'(i));
    @(negedge mclk); addr = 10'h9; chip_sel_n = 0; read_write = 1;
    @(negedge mclk); chip_sel_n = 1; load_or_advance = 1;
    @(negedge mclk); cycle_hold_n = 1;
    repeat (2) @(negedge mclk);
    chk(36'(dq_oe), 36'hf);
    chk(dq_out, mem[9]);
    cycle_hold_n = 0;
    for (int k = 0; k < 3; k++) begin
      @(negedge mclk);
      if (k == 1) load_or_advance = 0;
      chk(dq_out, mem[8 + (k + 2) % 4]);
    end
    burst(10'h9, 1'b1);
    sleep_request = 1;
    repeat (8) @(negedge mclk);
    chk(36'(asleep), 36'h1);
    sleep_request = 0;
    repeat (8) @(negedge mclk);
    chk(36'(asleep), 36'h0);
    rd(10'h4, 4'hf);
    finish_test;
  end
endmodule : test_sram_burst_bytewrite_sleep
